// >>> eecmd_defines.svh
/*
  Constants of the serial EEPROM command front end: opcodes, array and
  page geometry, status bit positions, reset values and cycle times.
  Assumes inclusion by bare name from the core, checker and bench files.
*/
`ifndef EECMD_DEFINES_SVH
`define EECMD_DEFINES_SVH

// opcodes
`define EECMD_OP_READ       8'h03
`define EECMD_OP_WRITE      8'h02
`define EECMD_OP_LATCH_SET  8'h06
`define EECMD_OP_LATCH_CLR  8'h04
`define EECMD_OP_STS_READ   8'h05
`define EECMD_OP_STS_WRITE  8'h01
`define EECMD_OP_PAGE_ERASE 8'h42
`define EECMD_OP_SECT_ERASE 8'hD8
`define EECMD_OP_CHIP_ERASE 8'hC7
`define EECMD_OP_WAKE       8'hAB
`define EECMD_OP_SLEEP      8'hB9

// geometry
`define EECMD_ADDR_BITS     16
`define EECMD_PAGE_BITS     7
`define EECMD_PAGE_SIZE     128
`define EECMD_SECT_BITS     14

// status bit positions
`define EECMD_SR_BUSY       0
`define EECMD_SR_WEL        1
`define EECMD_SR_BP_LO      2
`define EECMD_SR_BP_HI      3
`define EECMD_SR_PROTECT_PIN_ENABLE_BIT       7

// reset values of the protection bits
`define EECMD_BP_RESET      2'h0
`define EECMD_PROTECT_PIN_ENABLE_BIT_RESET    1'b0

// times and system clock rate
`define EECMD_TWC_MS        5
`define EECMD_TERASE_MS     10
`define EECMD_CLK_KHZ       25000

`endif

// >>> eecmd_pkg.sv
/*
  Types of the serial EEPROM command front end.
  Assumes nothing beyond the constants header.
*/
package eecmd_pkg;
  // serial sequence phase on the link clock
  typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DIN, PH_DOUT, PH_IDLE} eecmd_phase_t;
  // internal program cycle walker
  typedef enum logic [1:0] {WK_IDLE, WK_READ, WK_WRITE, WK_WAIT} eecmd_walk_t;
endpackage

// >>> eecmd_mem.sv
/*
  Two-clock byte memory: port a reads and writes on clk_a, port b reads
  on clk_b. Read data come from registers. Assumes the caller never
  writes a word on one port while the other port reads that same word.
*/
`timescale 1ns/1ps
module eecmd_mem #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  // port a, read and write
  input  wire logic          clk_a,
  input  wire logic          en_a,
  input  wire logic          we_a,
  input  wire logic [AW-1:0] addr_a,
  input  wire logic [DW-1:0] wdata_a,
  output logic      [DW-1:0] rdata_a,
  // port b, read only
  input  wire logic          clk_b,
  input  wire logic          en_b,
  input  wire logic [AW-1:0] addr_b,
  output logic      [DW-1:0] rdata_b
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // port a: read returns the old word on a write
  always_ff @(posedge clk_a) begin
    if (en_a) begin
      if (we_a) begin
        mem[addr_a] <= wdata_a;
      end
      rdata_a <= mem[addr_a];
    end
  end

  // port b
  always_ff @(posedge clk_b) begin
    if (en_b) begin
      rdata_b <= mem[addr_b];
    end
  end
endmodule

// >>> eecmd_core.sv
/*
  Serial command front end of a 64 KiB EEPROM: bit engine on the link
  clock sck, program cycle walker and write enable latch on clk.
  Assumes the host stops sck while cs_n is high and keeps cs_n high at
  least three clk periods between frames; sck-side words read by clk
  are stable then.
*/
// Summary of operation
// - sample serial input on rising sck
// - change serial output after falling sck
// - shift msb first, 8-bit opcode register
// - first bit on first rise after select
// - pause starts with hold low, sck low
// - resume with hold high, sck low
// - paused: ignore edges, keep sequence state
// - output floats at once on hold low
// - decode array read and array write
// - decode latch set and latch clear
// - decode page, sector and chip erase
// - decode wake-signature and deep sleep
// - read streams bytes until select rises
// - read pointer increments, wraps to zero
// - latch set only if select rises after opcode
// - write is opcode, address, 1-128 bytes
// - write data wraps within its page
// - short write reprograms whole page
// - program only if select rises after byte
// - busy: status readable, array reads refused
// - latch clears at reset, on latch clear, after status write and at cycle end
// - busy flag shows active internal cycle
// - latch flag readable; writes need latch
// - write or page erase within 5 ms
// - output floats while deselected
`timescale 1ns/1ps
`include "eecmd_defines.svh"
module eecmd_core #(
  parameter int         TWC_CYC    = `EECMD_TWC_MS * `EECMD_CLK_KHZ,
  parameter int         TERASE_CYC = `EECMD_TERASE_MS * `EECMD_CLK_KHZ,
  parameter logic [7:0] SIG_CODE   = 8'h5A  // arbitrary value
) (
  // system clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // serial link from the host
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic sdi,
  input  wire logic hold_n,
  input  wire logic wp_n,
  // serial output, driven while so_oe_n is low
  output logic      so_out,
  output logic      so_oe_n
);
  localparam int AW = `EECMD_ADDR_BITS;
  localparam int PW = `EECMD_PAGE_BITS;
  localparam int TW = $clog2(TERASE_CYC + 1);

  // link domain state
  logic                        fresh_reg;
  eecmd_pkg::eecmd_phase_t     ph_reg, ph_next, ph_cur;
  logic [2:0]                  cnt_reg, cnt_next, cnt_cur;
  logic [7:0]                  sh_reg, sh_in;
  logic [7:0]                  cmd_reg, cmd_next;
  logic [7:0]                  src_reg, src_next;
  logic [7:0]                  stwr_reg, stwr_next;
  logic [AW-1:0]               addr_reg, addr_next;
  logic                        abyte_reg, abyte_next;
  logic                        end_ok_reg, end_ok_next;
  logic [`EECMD_PAGE_SIZE-1:0] touched_reg, touched_next;
  logic [5:0]                  sv_s1_reg, sv_s2_reg;
  logic                        so_q_reg, so_en_reg;

  // system domain state
  logic                        cs1_reg, cs2_reg, cs3_reg;
  logic                        wp1_reg, wp2_reg;
  eecmd_pkg::eecmd_walk_t      walk_reg, walk_next;
  logic [AW:0]                 idx_reg, idx_next, last_reg, last_next;
  logic [AW-1:0]               base_reg, base_next;
  logic                        erase_reg, erase_next;
  logic [TW-1:0]               tmr_reg, tmr_next;
  logic                        busy_reg;
  logic                        wel_reg, wel_next, protect_pin_enable_bit_reg, protect_pin_enable_bit_next;
  logic [1:0]                  bp_reg, bp_next;
  logic                        sleep_reg, sleep_next;

  // memories
  logic [7:0]                  arr_rd_a, arr_rd_b, buf_rd_b, arr_wdata;
  logic                        buf_we, arr_rd_en_b;
  logic [AW-1:0]               arr_rd_addr_b;

  // synchronised view of system state on the link clock
  wire       busy_s  = sv_s2_reg[4];
  wire       sleep_s = sv_s2_reg[5];
  wire       wel_s   = sv_s2_reg[3];
  wire       protect_pin_enable_bit_s  = sv_s2_reg[2];
  wire [1:0] bp_s    = sv_s2_reg[1:0];
  logic [7:0] sts_byte;

  // status byte as seen by the host
  always_comb begin
    sts_byte                     = 8'h00;
    sts_byte[`EECMD_SR_BUSY]     = busy_s;
    sts_byte[`EECMD_SR_WEL]      = wel_s;
    sts_byte[`EECMD_SR_BP_LO]    = bp_s[0];
    sts_byte[`EECMD_SR_BP_HI]    = bp_s[1];
    sts_byte[`EECMD_SR_PROTECT_PIN_ENABLE_BIT]     = protect_pin_enable_bit_s;
  end

  // decode on the current bit
  assign cnt_cur = fresh_reg ? 3'd0 : cnt_reg;
  assign ph_cur  = fresh_reg ? eecmd_pkg::PH_OPC : ph_reg;
  assign sh_in   = {sh_reg[6:0], sdi};
  wire byte_done = (cnt_cur == 3'd7);
  wire cmd_read  = (cmd_reg == `EECMD_OP_READ);
  wire cmd_write = (cmd_reg == `EECMD_OP_WRITE);
  // while busy only the status read is taken, while asleep only wake
  wire op_ok = sleep_s ? (sh_in == `EECMD_OP_WAKE)
                       : (!busy_s || sh_in == `EECMD_OP_STS_READ);

  // sequence engine, next state for each rising sck
  always_comb begin
    ph_next      = ph_cur;
    cnt_next     = cnt_cur + 3'd1;
    cmd_next     = cmd_reg;
    src_next     = src_reg;
    stwr_next    = stwr_reg;
    addr_next    = addr_reg;
    abyte_next   = abyte_reg;
    end_ok_next  = 1'b0;  // any further bit spoils a clean end
    touched_next = touched_reg;
    case (ph_cur)
      eecmd_pkg::PH_OPC: begin
        if (byte_done) begin
          cmd_next   = sh_in;
          abyte_next = 1'b0;
          ph_next    = eecmd_pkg::PH_IDLE;  // unknown, refused or single-byte opcode
          if (op_ok) begin
            case (sh_in)
              `EECMD_OP_READ,
              `EECMD_OP_PAGE_ERASE,
              `EECMD_OP_SECT_ERASE: begin
                ph_next = eecmd_pkg::PH_ADDR;
              end
              `EECMD_OP_WRITE: begin
                ph_next      = eecmd_pkg::PH_ADDR;
                touched_next = '0;
              end
              `EECMD_OP_STS_READ: begin
                ph_next  = eecmd_pkg::PH_DOUT;
                src_next = sts_byte;
              end
              `EECMD_OP_WAKE: begin
                ph_next  = eecmd_pkg::PH_DOUT;
                src_next = SIG_CODE;
              end
              `EECMD_OP_STS_WRITE: begin
                ph_next = eecmd_pkg::PH_DIN;
              end
              `EECMD_OP_LATCH_SET,
              `EECMD_OP_LATCH_CLR,
              `EECMD_OP_CHIP_ERASE,
              `EECMD_OP_SLEEP: begin
                end_ok_next = 1'b1;
              end
              default: begin
                ph_next = eecmd_pkg::PH_IDLE;
              end
            endcase
          end
        end
      end
      eecmd_pkg::PH_ADDR: begin
        addr_next = {addr_reg[AW-2:0], sdi};
        if (byte_done) begin
          abyte_next = 1'b1;
          if (abyte_reg) begin
            if (cmd_read) begin
              ph_next = eecmd_pkg::PH_DOUT;
            end else if (cmd_write) begin
              ph_next = eecmd_pkg::PH_DIN;
            end else begin
              ph_next     = eecmd_pkg::PH_IDLE;
              end_ok_next = 1'b1;
            end
          end
        end
      end
      eecmd_pkg::PH_DIN: begin
        if (byte_done) begin
          if (cmd_write) begin
            touched_next[addr_reg[PW-1:0]] = 1'b1;
            // column wraps inside the page
            addr_next[PW-1:0] = addr_reg[PW-1:0] + {{(PW-1){1'b0}}, 1'b1};
            end_ok_next       = 1'b1;
          end else begin
            stwr_next   = sh_in;
            ph_next     = eecmd_pkg::PH_IDLE;
            end_ok_next = 1'b1;
          end
        end
      end
      eecmd_pkg::PH_DOUT: begin
        if (byte_done) begin
          if (cmd_read) begin
            addr_next = addr_reg + 16'h0001;  // wraps to zero
          end else if (cmd_reg == `EECMD_OP_STS_READ) begin
            src_next = sts_byte;
          end
        end
      end
      default: begin
        ph_next = eecmd_pkg::PH_IDLE;
      end
    endcase
  end

  // next byte fetched at the last bit so it is ready for the fall
  assign arr_rd_en_b = hold_n && byte_done && cmd_read &&
                       ((ph_cur == eecmd_pkg::PH_ADDR && abyte_reg) ||
                        ph_cur == eecmd_pkg::PH_DOUT);
  assign arr_rd_addr_b = (ph_cur == eecmd_pkg::PH_ADDR) ? {addr_reg[AW-2:0], sdi}
                                                        : addr_reg + 16'h0001;
  assign buf_we = hold_n && byte_done && cmd_write && ph_cur == eecmd_pkg::PH_DIN;

  // frame start marker: cleared by the first rise after select
  always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst) begin
      fresh_reg <= 1'b1;
    end else if (cs_n) begin
      fresh_reg <= 1'b1;
    end else if (hold_n) begin
      fresh_reg <= 1'b0;
    end
  end

  // sequence registers, frozen while hold is low
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      ph_reg      <= eecmd_pkg::PH_IDLE;
      cnt_reg     <= 3'd0;
      sh_reg      <= 8'h00;
      cmd_reg     <= 8'h00;
      src_reg     <= 8'h00;
      stwr_reg    <= 8'h00;
      addr_reg    <= 16'h0000;
      abyte_reg   <= 1'b0;
      end_ok_reg  <= 1'b0;
      touched_reg <= '0;
    end else if (hold_n) begin
      ph_reg      <= ph_next;
      cnt_reg     <= cnt_next;
      sh_reg      <= sh_in;
      cmd_reg     <= cmd_next;
      src_reg     <= src_next;
      stwr_reg    <= stwr_next;
      addr_reg    <= addr_next;
      abyte_reg   <= abyte_next;
      end_ok_reg  <= end_ok_next;
      touched_reg <= touched_next;
    end
  end

  // system state into the link domain, two flops
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      sv_s1_reg <= 6'h00;
      sv_s2_reg <= 6'h00;
    end else begin
      sv_s1_reg <= {sleep_reg, busy_reg, wel_reg, protect_pin_enable_bit_reg, bp_reg};
      sv_s2_reg <= sv_s1_reg;
    end
  end

  // output bit changes only on the falling edge
  wire [7:0] out_byte = cmd_read ? arr_rd_b : src_reg;
  always_ff @(negedge sck or negedge nrst) begin
    if (!nrst) begin
      so_q_reg  <= 1'b0;
      so_en_reg <= 1'b0;
    end else if (hold_n) begin
      so_q_reg  <= out_byte[3'd7 - cnt_reg];
      so_en_reg <= (ph_reg == eecmd_pkg::PH_DOUT) && !fresh_reg;
    end
  end

  // pins gate the enable directly so float and drive are immediate
  assign so_out  = so_q_reg;
  assign so_oe_n = ~(so_en_reg && ph_reg == eecmd_pkg::PH_DOUT && !fresh_reg &&
                     !cs_n && hold_n);

  // page buffer: filled on sck, drained on clk during the cycle
  eecmd_mem #(.DW(8), .AW(PW)) u_page_buf (
    .clk_a   (sck),
    .en_a    (buf_we),
    .we_a    (buf_we),
    .addr_a  (addr_reg[PW-1:0]),
    .wdata_a (sh_in),
    .rdata_a (),
    .clk_b   (clk),
    .en_b    (walk_reg == eecmd_pkg::WK_READ),
    .addr_b  (idx_reg[PW-1:0]),
    .rdata_b (buf_rd_b)
  );

  // array: programmed on clk, streamed out on sck
  eecmd_mem #(.DW(8), .AW(AW)) u_array (
    .clk_a   (clk),
    .en_a    (walk_reg == eecmd_pkg::WK_READ || walk_reg == eecmd_pkg::WK_WRITE),
    .we_a    (walk_reg == eecmd_pkg::WK_WRITE),
    .addr_a  (base_reg + idx_reg[AW-1:0]),
    .wdata_a (arr_wdata),
    .rdata_a (arr_rd_a),
    .clk_b   (sck),
    .en_b    (arr_rd_en_b),
    .addr_b  (arr_rd_addr_b),
    .rdata_b (arr_rd_b)
  );

  // untouched bytes are rewritten with their own contents
  assign arr_wdata = erase_reg ? 8'hFF
                   : (touched_reg[idx_reg[PW-1:0]] ? buf_rd_b : arr_rd_a);

  // select and write-protect pins into the system domain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs1_reg <= 1'b1;
      cs2_reg <= 1'b1;
      cs3_reg <= 1'b1;
      wp1_reg <= 1'b1;
      wp2_reg <= 1'b1;
    end else begin
      cs1_reg <= cs_n;
      cs2_reg <= cs1_reg;
      cs3_reg <= cs2_reg;
      wp1_reg <= wp_n;
      wp2_reg <= wp1_reg;
    end
  end

  // command completion at the rise of select
  wire       cs_rise   = cs2_reg && !cs3_reg;
  wire       exec      = cs_rise && end_ok_reg && !busy_reg;
  wire [1:0] lim       = (bp_reg == 2'd1) ? 2'd3 : (bp_reg == 2'd2) ? 2'd2 : 2'd0;
  wire       prot_addr = (bp_reg != 2'd0) && (addr_reg[AW-1:AW-2] >= lim);
  wire       sr_locked = protect_pin_enable_bit_reg && !wp2_reg;
  wire       is_page   = cmd_write || cmd_reg == `EECMD_OP_PAGE_ERASE;
  wire       is_sect   = (cmd_reg == `EECMD_OP_SECT_ERASE);
  wire       is_chip   = (cmd_reg == `EECMD_OP_CHIP_ERASE);
  wire       start_arr = exec && wel_reg &&
                         (((is_page || is_sect) && !prot_addr) ||
                          (is_chip && bp_reg == 2'd0));
  wire       wake_seen = cs_rise && ph_reg != eecmd_pkg::PH_OPC &&
                         cmd_reg == `EECMD_OP_WAKE;

  // latch, protection bits and cycle walker
  always_comb begin
    walk_next  = walk_reg;
    idx_next   = idx_reg;
    last_next  = last_reg;
    base_next  = base_reg;
    erase_next = erase_reg;
    tmr_next   = (tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
    wel_next   = wel_reg;
    protect_pin_enable_bit_next  = protect_pin_enable_bit_reg;
    bp_next    = bp_reg;
    sleep_next = wake_seen ? 1'b0 : sleep_reg;
    case (walk_reg)
      eecmd_pkg::WK_IDLE: begin
        if (start_arr) begin
          walk_next  = eecmd_pkg::WK_READ;
          idx_next   = '0;
          erase_next = !cmd_write;
          if (is_page) begin
            base_next = {addr_reg[AW-1:PW], {PW{1'b0}}};
            last_next = 17'h0_007F;
            tmr_next  = TW'(TWC_CYC);
          end else if (is_sect) begin
            base_next = {addr_reg[AW-1:`EECMD_SECT_BITS], {`EECMD_SECT_BITS{1'b0}}};
            last_next = 17'h0_3FFF;
            tmr_next  = TW'(TERASE_CYC);
          end else begin
            base_next = 16'h0000;
            last_next = 17'h0_FFFF;
            tmr_next  = TW'(TERASE_CYC);
          end
        end else if (exec) begin
          case (cmd_reg)
            `EECMD_OP_LATCH_SET: wel_next = 1'b1;
            `EECMD_OP_LATCH_CLR: wel_next = 1'b0;
            `EECMD_OP_SLEEP:     sleep_next = 1'b1;
            `EECMD_OP_STS_WRITE: begin
              if (wel_reg) begin
                wel_next = 1'b0;
                if (!sr_locked) begin
                  protect_pin_enable_bit_next = stwr_reg[`EECMD_SR_PROTECT_PIN_ENABLE_BIT];
                  bp_next   = stwr_reg[`EECMD_SR_BP_HI:`EECMD_SR_BP_LO];
                end
              end
            end
            default: wel_next = wel_reg;
          endcase
        end
      end
      eecmd_pkg::WK_READ: begin
        walk_next = eecmd_pkg::WK_WRITE;
      end
      eecmd_pkg::WK_WRITE: begin
        idx_next  = idx_reg + 17'h0_0001;
        walk_next = (idx_reg == last_reg) ? eecmd_pkg::WK_WAIT : eecmd_pkg::WK_READ;
      end
      eecmd_pkg::WK_WAIT: begin
        if (tmr_reg == '0) begin
          walk_next = eecmd_pkg::WK_IDLE;
          wel_next  = 1'b0;
        end
      end
      default: begin
        walk_next = eecmd_pkg::WK_IDLE;
      end
    endcase
  end

  // system domain registers; latch clear at reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      walk_reg  <= eecmd_pkg::WK_IDLE;
      idx_reg   <= '0;
      last_reg  <= '0;
      base_reg  <= 16'h0000;
      erase_reg <= 1'b0;
      tmr_reg   <= '0;
      busy_reg  <= 1'b0;
      wel_reg   <= 1'b0;
      protect_pin_enable_bit_reg  <= `EECMD_PROTECT_PIN_ENABLE_BIT_RESET;
      bp_reg    <= `EECMD_BP_RESET;
      sleep_reg <= 1'b0;
    end else begin
      walk_reg  <= walk_next;
      idx_reg   <= idx_next;
      last_reg  <= last_next;
      base_reg  <= base_next;
      erase_reg <= erase_next;
      tmr_reg   <= tmr_next;
      busy_reg  <= (walk_next != eecmd_pkg::WK_IDLE);
      wel_reg   <= wel_next;
      protect_pin_enable_bit_reg  <= protect_pin_enable_bit_next;
      bp_reg    <= bp_next;
      sleep_reg <= sleep_next;
    end
  end
endmodule

// >>> eecmd_properties.sv
/* pin-level assertions on the eeprom serial core.
   assumes the host moves hold only while sck is low. */
`timescale 1ns/1ps
`include "eecmd_defines.svh"
module eecmd_properties (
  // system side
  input wire logic clk,
  input wire logic nrst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_out,
  input wire logic so_oe_n
);
  logic [4:0] cnt_reg;
  logic [7:0] opc_reg;
  logic       drv_reg;
  // rises of the frame, saturating; paused rises are not counted
  // reset too, so the first frame is not counted from an unknown start
  always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst || cs_n) begin
      cnt_reg <= 5'h00;
      opc_reg <= 8'h00;
    end else if (hold_n && cnt_reg != 5'h1f) begin
      cnt_reg <= cnt_reg + 5'h01;
      opc_reg <= (cnt_reg < 5'h08) ? {opc_reg[6:0], sdi} : opc_reg;
    end
  end
  // whether the pin was driven just before a pause
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) drv_reg <= 1'b0;
    else if (cs_n) drv_reg <= 1'b0;
    else if (hold_n) drv_reg <= !so_oe_n;
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_float_deselected: assert property (cs_n |-> so_oe_n)
    else $error("output driven while deselected");
  a_float_on_hold: assert property (!hold_n |-> so_oe_n)
    else $error("output driven while paused");
  a_change_sck_low: assert property ($changed(so_out) |-> !sck)
    else $error("output moved while sck high");
  a_pause_frozen: assert property (!hold_n && !$past(hold_n) |-> $stable(so_out))
    else $error("output moved during pause");
  a_quiet_opcode: assert property (!so_oe_n |-> cnt_reg >= 5'h08)
    else $error("output before opcode complete");
  a_read_after_addr: assert property (!so_oe_n &&
    opc_reg == `EECMD_OP_READ |-> cnt_reg >= 5'h18)
    else $error("read data before address complete");
  a_unknown_quiet: assert property (cnt_reg >= 5'h08 &&
    !(opc_reg inside {`EECMD_OP_READ, `EECMD_OP_STS_READ, `EECMD_OP_WAKE}) |-> so_oe_n)
    else $error("output after non-reading opcode");
  a_stream_goes_on: assert property ((!so_oe_n && !cs_n) ##1
    (!cs_n && hold_n) |-> !so_oe_n)
    else $error("read stream stopped inside frame");
  a_drive_on_resume: assert property ($rose(hold_n) && !cs_n && drv_reg |-> !so_oe_n)
    else $error("output not restored after pause");
endmodule
bind eecmd_core eecmd_properties u_props (.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n),
  .sdi(sdi), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n));

// >>> eecmd_host.sv
/* host model of the serial link: frames, bytes and pauses.
   assumes the bench resolves the data-out pin into so_w. */
`timescale 1ns/1ps
module eecmd_host (
  // link driven by the host
  output logic sck    = 1'b0,
  output logic cs_n   = 1'b1,
  output logic sdi    = 1'b0,
  output logic hold_n = 1'b1,
  // resolved data-out pin
  input  wire logic so_w
);
  int hold_at = -1;  // frame bit before which to pause once
  int nbit;
  // select; sck stays low outside frames
  task automatic start();
    #37 cs_n = 1'b0;
    nbit = 0;
  endtask
  // sdi moves after the fall so the device takes it at the rise
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (nbit == hold_at) pause();
      nbit++;
      sdi = tx[i];
      #80 sck = 1'b1;
      rx[i] = so_w;
      #80 sck = 1'b0;
    end
  endtask
  // pause entered and left with sck low; wiggles must be ignored
  task automatic pause();
    #20 hold_n = 1'b0;  // after the fall, which must still count
    #100 sck = 1'b1;
    sdi = ~sdi;
    #100 sck = 1'b0;
    #100 hold_n = 1'b1;
    hold_at = -1;
    #40;
  endtask
  // deselect; sdi shows no stale level afterwards
  task automatic stop();
    #60 cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule

// >>> eecmd_core_tb.sv
/* self-checking bench of the eeprom serial core.
   assumes the host model and the bound checker. */
`timescale 1ns/1ps
`include "eecmd_defines.svh"
module eecmd_core_tb;
  logic       clk  = 1'b0;
  logic       nrst = 1'b1;
  logic       wp_n = 1'b1;
  logic       sck, cs_n, sdi, hold_n, so_out, so_oe_n;
  wire        so_w = so_oe_n ? 1'bz : so_out;  // pin floats when released
  int         err_total = 0;
  int         n_checks = 0;
  logic [7:0] rx;
  initial begin
    forever #20 clk = ~clk;
  end
  eecmd_core #(.TWC_CYC(300), .TERASE_CYC(600), .SIG_CODE(8'hc3)) uut (.clk(clk),
    .nrst(nrst), .sck(sck), .cs_n(cs_n), .sdi(sdi), .hold_n(hold_n), .wp_n(wp_n),
    .so_out(so_out), .so_oe_n(so_oe_n));
  eecmd_host host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .hold_n(hold_n), .so_w(so_w));
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    host.start();
    host.xbyte(op, rx);
    host.stop();
  endtask
  task automatic st_is(input logic [7:0] e);
    host.start();
    host.xbyte(`EECMD_OP_STS_READ, rx);
    host.xbyte(8'h00, rx);
    host.stop();
    chk("status", e, rx);
  endtask
  // bounded poll of the busy bit
  task automatic wait_idle();
    for (int i = 0; i < 800; i++) begin
      host.start();
      host.xbyte(`EECMD_OP_STS_READ, rx);
      host.xbyte(8'h00, rx);
      host.stop();
      if (rx[`EECMD_SR_BUSY] === 1'b0) return;
    end
    err_total++;
    end_sim();
  endtask
  // opcode then address, high byte first
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    host.start();
    host.xbyte(op, rx);
    host.xbyte(a[15:8], rx);
    host.xbyte(a[7:0], rx);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    hdr(`EECMD_OP_READ, a);
    host.xbyte(8'h00, rx);
    chk("read first", e0, rx);
    host.xbyte(8'h00, rx);
    chk("read next", e1, rx);
    host.stop();
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] v);
    cmd(`EECMD_OP_LATCH_SET);
    hdr(`EECMD_OP_WRITE, a);
    for (int i = 0; i < n; i++) host.xbyte(v + 8'(i), rx);
    host.stop();
  endtask
  task automatic t_latch();
    st_is(8'h00);
    cmd(`EECMD_OP_LATCH_SET);
    st_is(8'h02);
    cmd(`EECMD_OP_LATCH_CLR);
    st_is(8'h00);
    cmd(`EECMD_OP_LATCH_SET);
    host.start();
    host.xbyte(`EECMD_OP_STS_WRITE, rx);
    host.xbyte(8'h00, rx);
    host.stop();
    st_is(8'h00);
    $display("t_latch done");
  endtask
  task automatic t_write();
    wr(16'h1210, 2, 8'h55);
    st_is(8'h03);
    rd(16'h1210, 8'hzz, 8'hzz);
    wait_idle();
    st_is(8'h00);
    wr(16'h127e, 4, 8'ha0);
    wait_idle();
    rd(16'h127e, 8'ha0, 8'ha1);
    rd(16'h1200, 8'ha2, 8'ha3);
    rd(16'h1210, 8'h55, 8'h56);
    wr(16'hffff, 1, 8'h11);
    wait_idle();
    wr(16'h0000, 1, 8'h22);
    wait_idle();
    rd(16'hffff, 8'h11, 8'h22);
    $display("t_write done");
  endtask
  task automatic t_refuse();
    hdr(`EECMD_OP_WRITE, 16'h1210);
    host.xbyte(8'h99, rx);
    host.stop();
    st_is(8'h00);
    cmd(`EECMD_OP_LATCH_SET);
    hdr(`EECMD_OP_WRITE, 16'h1210);
    host.stop();
    st_is(8'h02);
    cmd(`EECMD_OP_LATCH_CLR);
    hdr(`EECMD_OP_LATCH_SET, {`EECMD_OP_WRITE, 8'h12});
    host.xbyte(8'h10, rx);
    host.xbyte(8'h77, rx);
    host.stop();
    st_is(8'h00);
    rd(16'h1210, 8'h55, 8'h56);
    hdr(8'hff, 16'h0000);
    host.stop();
    chk("unknown opcode", 8'hzz, rx);
    cmd(`EECMD_OP_CHIP_ERASE);
    st_is(8'h00);
    $display("t_refuse done");
  endtask
  task automatic t_erase();
    cmd(`EECMD_OP_LATCH_SET);
    hdr(`EECMD_OP_PAGE_ERASE, 16'h1234);
    host.stop();
    st_is(8'h03);
    wait_idle();
    rd(16'h1210, 8'hff, 8'hff);
    cmd(`EECMD_OP_LATCH_SET);
    hdr(`EECMD_OP_SECT_ERASE, 16'hc000);
    host.stop();
    wait_idle();
    st_is(8'h00);
    rd(16'hffff, 8'hff, 8'h22);
    $display("t_erase done");
  endtask
  task automatic t_sleep_hold();
    cmd(`EECMD_OP_SLEEP);
    st_is(8'hzz);
    host.start();
    host.xbyte(`EECMD_OP_WAKE, rx);
    host.xbyte(8'h00, rx);
    host.stop();
    chk("signature", 8'hc3, rx);
    host.hold_at = 5;
    rd(16'hffff, 8'hff, 8'h22);
    host.hold_at = 34;  // inside the mixed byte, so a lost shift shows
    rd(16'hffff, 8'hff, 8'h22);
    $display("t_sleep_hold done");
  endtask
  initial begin
    #1 nrst = 1'b0;  // a real falling edge reaches every async reset
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_latch();
    t_write();
    t_refuse();
    t_erase();
    t_sleep_hold();
    end_sim();
  end
  // cuts a hang short
  initial begin
    #3_900_000;
    err_total++;
    end_sim();
  end
endmodule
